//--- sswc_pkg.sv
// package for the serial shift wire/clock control block
// assumes an avalon-mm slave with 32-bit data, byte addressed words
package sswc_pkg;
  // register byte addresses
  localparam logic [3:0] SSWC_CTRL_OFS = 4'h0;
  localparam logic [3:0] SSWC_STAT_OFS = 4'h4;
  localparam logic [3:0] SSWC_DATA_OFS = 4'h8;
  localparam logic [3:0] SSWC_PORT_OFS = 4'hC;
  // control field positions
  localparam int SSWC_OIE_BIT = 6;
  localparam int SSWC_WM_LSB = 4;
  localparam int SSWC_CS_LSB = 2;
  localparam int SSWC_CLK_BIT = 1;
  localparam int SSWC_TC_BIT = 0;
  // status field positions
  localparam int SSWC_SIF_BIT = 7;
  localparam int SSWC_OIF_BIT = 6;
  // port/direction register fields
  localparam int SSWC_DO_PORT_BIT = 0;
  localparam int SSWC_DI_PORT_BIT = 1;
  localparam int SSWC_CK_PORT_BIT = 2;
  localparam int SSWC_DO_DIR_BIT = 4;
  localparam int SSWC_DI_DIR_BIT = 5;
  localparam int SSWC_CK_DIR_BIT = 6;
  // reset values and counter maximum
  localparam logic [7:0] SSWC_CTRL_RST = 8'h00;
  localparam logic [7:0] SSWC_DATA_RST = 8'h00;
  localparam logic [7:0] SSWC_PORT_RST = 8'h00;
  localparam logic [3:0] SSWC_CNT_RST = 4'h0;
  localparam logic [3:0] SSWC_CNT_MAX = 4'hF;
  // wire modes and clock sources
  localparam logic [1:0] SSWC_WM_OFF = 2'h0;
  localparam logic [1:0] SSWC_WM_THREE = 2'h1;
  localparam logic [1:0] SSWC_WM_TWO_HOLD = 2'h3;
  localparam logic [1:0] SSWC_CS_SOFT = 2'h0;
  localparam logic [1:0] SSWC_CS_TIMER = 2'h1;
  localparam logic [1:0] SSWC_CS_NEG = 2'h3;
  // input synchroniser depth
  localparam int SSWC_SYNC_STAGES = 3;

  typedef struct packed {
    logic oie;
    logic [1:0] wm;
    logic [1:0] cs;
    logic clk_sel;
  } sswc_ctrl_t;

  typedef struct packed {
    logic do_oe;
    logic do_o;
    logic sda_oe;
    logic scl_oe;
    logic scl_o;
    logic di_pu;
    logic ck_pu;
  } sswc_pins_t;
endpackage

//--- sswc_sync.sv
// three-flop synchroniser with agreement filter for one pin
// assumes the input is asynchronous to sys_clk_i
`timescale 1ns/1ns
`default_nettype none
module sswc_sync
  import sswc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // pin and filtered level
  input wire logic pin_i,
  output logic level_o
);
  typedef struct packed {
    logic [SSWC_SYNC_STAGES-1:0] ff;
    logic level;
  } sswc_sync_state_t;

  sswc_sync_state_t state_reg;
  sswc_sync_state_t state_next;

  // first flop only feeds the second; change counts once stages 2 and 3 agree
  always_comb
  begin
    state_next = state_reg;
    state_next.ff = {state_reg.ff[SSWC_SYNC_STAGES-2:0], pin_i};
    if (state_reg.ff[1] == state_reg.ff[2])
    begin
      state_next.level = state_reg.ff[2];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign level_o = state_reg.level;
endmodule
`default_nettype wire

//--- sswc_ctrl.sv
// serial shift unit control: wire modes, clock sources, strobes, counter
// assumes avalon-mm master on sys_clk_i; pins are synchronised here
`timescale 1ns/1ns
`default_nettype none
module sswc_ctrl
  import sswc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // system side
  input wire logic global_irq_enable_i,
  input wire logic timer_match_i,
  output logic overflow_irq_o,
  // serial pins
  input wire logic serial_in_pin_i,
  input wire logic serial_clock_pin_i,
  output logic data_out_o,
  output logic data_out_oe_o,
  output logic sda_o,
  output logic sda_oe_o,
  output logic scl_o,
  output logic scl_oe_o,
  output logic di_pullup_o,
  output logic ck_pullup_o
);
  typedef struct packed {
    sswc_ctrl_t ctrl;
    logic [7:0] shift_data_reg;
    logic [3:0] cnt;
    logic [7:0] port;
    logic sif;
    logic oif;
    logic latch;
    logic di_prev;
    logic ck_prev;
    logic sda_prev;
    logic [31:0] rdata;
    logic wait_n;
    logic irq;
    sswc_pins_t pins;
  } sswc_state_t;

  sswc_state_t state_reg;
  sswc_state_t state_next;
  logic di_lvl;
  logic ck_lvl;

  // inputs are synchronised regardless of wire mode
  sswc_sync u_sync_di (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(serial_in_pin_i),
    .level_o(di_lvl)
  );

  sswc_sync u_sync_ck (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .pin_i(serial_clock_pin_i),
    .level_o(ck_lvl)
  );

  function automatic logic sel_hit(input logic [3:0] addr, input logic [3:0] ofs);
    sel_hit = (addr == ofs);
  endfunction

  logic wr;
  logic rd;
  logic ck_rise;
  logic ck_fall;
  logic ext_src;
  logic shift_clk;
  logic cnt_clk;
  logic clk_strobe;
  logic tog_strobe;
  logic start_det;
  logic two_wire;
  logic [7:0] wbyte;
  logic latch_d;

  always_comb
  begin
    state_next = state_reg;
    wr = avs_write_i && state_reg.wait_n;
    rd = avs_read_i && !state_reg.wait_n;
    wbyte = avs_writedata_i[7:0];
    ck_rise = ck_lvl && !state_reg.ck_prev;
    ck_fall = !ck_lvl && state_reg.ck_prev;
    ext_src = state_reg.ctrl.cs[1];
    two_wire = state_reg.ctrl.wm[1];
    clk_strobe = wr && avs_byteenable_i[0] && sel_hit(avs_address_i, SSWC_CTRL_OFS)
      && wbyte[SSWC_CLK_BIT];
    tog_strobe = wr && avs_byteenable_i[0] && sel_hit(avs_address_i, SSWC_CTRL_OFS)
      && wbyte[SSWC_TC_BIT];
    // start: sda falls while scl high, only in two-wire mode
    start_det = two_wire && state_reg.sda_prev && !di_lvl && ck_lvl;
    shift_clk = 1'b0;
    cnt_clk = 1'b0;
    case (state_reg.ctrl.cs)
      SSWC_CS_SOFT:
      begin
        shift_clk = clk_strobe;
        cnt_clk = clk_strobe;
      end
      SSWC_CS_TIMER:
      begin
        shift_clk = timer_match_i;
        cnt_clk = timer_match_i;
      end
      default:
      begin
        shift_clk = (state_reg.ctrl.cs == SSWC_CS_NEG) ? ck_fall : ck_rise;
        cnt_clk = state_reg.ctrl.clk_sel ? tog_strobe : (ck_rise || ck_fall);
      end
    endcase
    state_next.ck_prev = ck_lvl;
    state_next.sda_prev = di_lvl;
    state_next.di_prev = di_lvl;
    // register writes; a data write wins over a shift in the same cycle
    if (wr && avs_byteenable_i[0])
    begin
      if (sel_hit(avs_address_i, SSWC_CTRL_OFS))
      begin
        state_next.ctrl.oie = wbyte[SSWC_OIE_BIT];
        state_next.ctrl.wm = wbyte[SSWC_WM_LSB +: 2];
        state_next.ctrl.cs = wbyte[SSWC_CS_LSB +: 2];
        state_next.ctrl.clk_sel = wbyte[SSWC_CLK_BIT];
      end
      if (sel_hit(avs_address_i, SSWC_PORT_OFS))
      begin
        state_next.port = wbyte;
      end
    end
    // shift in the input level seen a cycle earlier
    if (shift_clk)
    begin
      state_next.shift_data_reg = {state_reg.shift_data_reg[6:0], state_reg.di_prev};
    end
    if (wr && avs_byteenable_i[0] && sel_hit(avs_address_i, SSWC_DATA_OFS))
    begin
      state_next.shift_data_reg = wbyte;
    end
    // counter; a direct write overrides an increment
    if (cnt_clk)
    begin
      state_next.cnt = state_reg.cnt + 4'h1;
    end
    if (wr && avs_byteenable_i[0] && sel_hit(avs_address_i, SSWC_STAT_OFS))
    begin
      state_next.cnt = wbyte[3:0];
      if (wbyte[SSWC_OIF_BIT])
      begin
        state_next.oif = 1'b0;
      end
      if (wbyte[SSWC_SIF_BIT])
      begin
        state_next.sif = 1'b0;
      end
    end
    // hardware set wins over software clear
    if (cnt_clk && state_reg.cnt == SSWC_CNT_MAX)
    begin
      state_next.oif = 1'b1;
    end
    if (start_det)
    begin
      state_next.sif = 1'b1;
    end
    // toggle strobe inverts clock port bit regardless of direction
    if (tog_strobe)
    begin
      state_next.port[SSWC_CK_PORT_BIT] = !state_reg.port[SSWC_CK_PORT_BIT];
    end
    // external source updates latch on the edge opposite sampling; else transparent
    latch_d = state_next.shift_data_reg[7];
    if (!ext_src)
    begin
      state_next.latch = latch_d;
    end
    else if ((state_reg.ctrl.cs == SSWC_CS_NEG) ? ck_rise : ck_fall)
    begin
      state_next.latch = latch_d;
    end
    // pin drive; pins follow the next-state values so they stay flop-driven
    state_next.pins = '0;
    state_next.pins.di_pu = !state_next.port[SSWC_DI_DIR_BIT] && state_next.port[SSWC_DI_PORT_BIT];
    state_next.pins.ck_pu = !state_next.port[SSWC_CK_DIR_BIT] && state_next.port[SSWC_CK_PORT_BIT];
    case (state_next.ctrl.wm)
      SSWC_WM_OFF:
      begin
        state_next.pins.do_oe = state_next.port[SSWC_DO_DIR_BIT];
        state_next.pins.do_o = state_next.port[SSWC_DO_PORT_BIT];
      end
      SSWC_WM_THREE:
      begin
        state_next.pins.do_oe = state_next.port[SSWC_DO_DIR_BIT];
        state_next.pins.do_o = state_next.latch;
      end
      default:
      begin
        state_next.pins.do_oe = state_next.port[SSWC_DO_DIR_BIT];
        state_next.pins.do_o = state_next.port[SSWC_DO_PORT_BIT];
        state_next.pins.di_pu = 1'b0;
        state_next.pins.ck_pu = 1'b0;
        state_next.pins.sda_oe = state_next.port[SSWC_DI_DIR_BIT]
          && !(state_next.latch && state_next.port[SSWC_DI_PORT_BIT]);
        state_next.pins.scl_oe = state_next.port[SSWC_CK_DIR_BIT]
          && (!state_next.port[SSWC_CK_PORT_BIT] || state_next.sif
          || (state_next.ctrl.wm == SSWC_WM_TWO_HOLD && state_next.oif));
      end
    endcase
    // pending overflow fires as soon as both enables are high
    state_next.irq = state_next.ctrl.oie && global_irq_enable_i && state_next.oif;
    // bus: one wait cycle, answer on the second
    state_next.wait_n = (avs_read_i || avs_write_i) && !state_reg.wait_n;
    if (rd)
    begin
      state_next.rdata = '0;
      case (avs_address_i)
        SSWC_CTRL_OFS:
        begin
          state_next.rdata[7:0] = {1'b0, state_reg.ctrl.oie, state_reg.ctrl.wm,
            state_reg.ctrl.cs, 2'b00};
        end
        SSWC_STAT_OFS:
        begin
          state_next.rdata[7:0] = {state_reg.sif, state_reg.oif, 2'b00, state_reg.cnt};
        end
        SSWC_DATA_OFS:
        begin
          state_next.rdata[7:0] = state_reg.shift_data_reg;
        end
        SSWC_PORT_OFS:
        begin
          state_next.rdata[7:0] = state_reg.port;
        end
        default:
        begin
          state_next.rdata = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= '0;
      state_reg.ctrl <= sswc_ctrl_t'(SSWC_CTRL_RST[6:1]);
      state_reg.shift_data_reg <= SSWC_DATA_RST;
      state_reg.port <= SSWC_PORT_RST;
      state_reg.cnt <= SSWC_CNT_RST;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign avs_readdata_o = state_reg.rdata;
  assign avs_waitrequest_o = !state_reg.wait_n;
  assign overflow_irq_o = state_reg.irq;
  assign data_out_o = state_reg.pins.do_o;
  assign data_out_oe_o = state_reg.pins.do_oe;
  assign sda_o = 1'b0 & state_reg.pins.sda_oe;
  assign sda_oe_o = state_reg.pins.sda_oe;
  assign scl_o = 1'b0 & state_reg.pins.scl_oe;
  assign scl_oe_o = state_reg.pins.scl_oe;
  assign di_pullup_o = state_reg.pins.di_pu;
  assign ck_pullup_o = state_reg.pins.ck_pu;
endmodule
`default_nettype wire

//--- sswc_ctrl_chk.sv
// port-level checker for the serial shift control block
// assumes it is bound to sswc_ctrl and sees only that module's ports
`timescale 1ns/1ns
`default_nettype none
module sswc_ctrl_chk
  import sswc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // bus
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // system side
  input wire logic global_irq_enable_i,
  input wire logic overflow_irq_o,
  // pins
  input wire logic data_out_oe_o,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic di_pullup_o,
  input wire logic ck_pullup_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  chk_strobe_zero: assert property (
    avs_read_i && avs_waitrequest_o && avs_address_i == SSWC_CTRL_OFS
    |=> avs_readdata_o[1:0] == 2'h0) else $error("strobe bits read back set");
  chk_sda_open: assert property (sda_oe_o |-> !sda_o)
    else $error("sda driven high");
  chk_scl_open: assert property (scl_oe_o |-> !scl_o)
    else $error("scl driven high");
  chk_irq_gate: assert property (!global_irq_enable_i |=> !overflow_irq_o)
    else $error("interrupt without global enable");
  chk_irq_rise: assert property ($rose(overflow_irq_o) |-> $past(global_irq_enable_i))
    else $error("interrupt rose while globally masked");
  chk_sda_pull: assert property (sda_oe_o |-> !di_pullup_o)
    else $error("sda pull-up on in two-wire");
  chk_scl_pull: assert property (scl_oe_o |-> !ck_pullup_o)
    else $error("scl pull-up on in two-wire");
  chk_pull_cross: assert property (sda_oe_o || scl_oe_o |-> !di_pullup_o && !ck_pullup_o)
    else $error("pull-up left on while a two-wire driver is enabled");
  cover property (overflow_irq_o);
  cover property (scl_oe_o);
  cover property (data_out_oe_o);
endmodule
bind sswc_ctrl sswc_ctrl_chk u_chk (.sys_clk_i, .rst_i, .avs_address_i, .avs_read_i,
  .avs_readdata_o, .avs_waitrequest_o, .global_irq_enable_i, .overflow_irq_o,
  .data_out_oe_o, .sda_o, .sda_oe_o, .scl_o, .scl_oe_o, .di_pullup_o, .ck_pullup_o);
`default_nettype wire

//--- sswc_peer.sv
// serial peer: drives clock and data pins at a 125 ns bit period
// assumes the bench resolves open-drain levels against the device drivers
`timescale 1ns/1ns
`default_nettype none
module sswc_peer (
  // pin drives toward the device
  output logic ck_o,
  output logic dt_o
);
  initial
  begin
    ck_o = 1'b0;
    dt_o = 1'b0;
  end
  // data is steady across both clock edges so either edge samples the same bit
  task automatic burst(input logic [2:0] k, input logic [7:0] b);
    for (int i = int'(k) - 1; i >= 0; i--)
    begin
      #31 dt_o = b[i];
      #31 ck_o = 1'b1;
      #63 ck_o = 1'b0;
    end
    // stale data is flipped after the frame so it never looks valid
    #31 dt_o = ~dt_o;
  endtask
  // start condition: data falls while the clock stands high, then the clock returns low
  task automatic start_cond();
    #31 dt_o = 1'b1;
    #31 ck_o = 1'b1;
    #63 dt_o = 1'b0;
    #63 ck_o = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- sswc_ctrl_bench.sv
// bench for the serial shift control block: bus tasks, serial peer, checks
// assumes one wait cycle per bus access and open-drain pins resolved here
`timescale 1ns/1ns
`default_nettype none
module sswc_ctrl_bench
  import sswc_pkg::*;
;
  logic sys_clk_i, rst_i, avs_read_i, avs_write_i, global_irq_enable_i, timer_match_i;
  logic [3:0] avs_address_i, avs_byteenable_i, n;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic avs_waitrequest_o, overflow_irq_o, data_out_o, data_out_oe_o, sda_o, sda_oe_o;
  logic scl_o, scl_oe_o, di_pullup_o, ck_pullup_o, pk, pd;
  logic [15:0] seed;
  logic [2:0] k;
  logic [7:0] c;
  int error_cnt, checks, cyc;
  logic [3:0] ofs [5] = '{SSWC_CTRL_OFS, SSWC_STAT_OFS, SSWC_DATA_OFS, SSWC_PORT_OFS, 4'h3};
  wire logic serial_in_pin_i = sda_oe_o ? 1'b0 : pd;
  wire logic serial_clock_pin_i = scl_oe_o ? 1'b0 : pk;
  sswc_ctrl dut (.sys_clk_i, .rst_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .global_irq_enable_i, .timer_match_i, .overflow_irq_o, .serial_in_pin_i,
    .serial_clock_pin_i, .data_out_o, .data_out_oe_o, .sda_o, .sda_oe_o, .scl_o,
    .scl_oe_o, .di_pullup_o, .ck_pullup_o);
  sswc_peer peer (.ck_o(pk), .dt_o(pd));
  always #2 sys_clk_i = ~sys_clk_i;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [7:0] stat(input logic f, input logic [3:0] cn);
    return {1'b0, f, 2'b00, cn};
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {24'h000000, d};
    do
      @(posedge sys_clk_i);
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic settle;
    repeat (8) @(posedge sys_clk_i);
  endtask
  task wrap_up;
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // a hang costs one mismatch and ends the run
  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      wrap_up;
    end
  end
  initial
  begin
    {sys_clk_i, avs_read_i, avs_write_i, global_irq_enable_i, timer_match_i} = 5'h00;
    rst_i = 1'b1;
    avs_address_i = 4'h0;
    avs_byteenable_i = 4'hF;
    avs_writedata_i = 32'h00000000;
    seed = 16'hD69B;
    repeat (10) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    wr(4'h3, 8'hFF);
    foreach (ofs[i])
      rdc(ofs[i], 8'h00);
    seed = lfsr(seed);
    n = {1'b0, seed[2:0]};
    wr(SSWC_CTRL_OFS, 8'h04);
    repeat (n)
    begin
      @(posedge sys_clk_i);
      timer_match_i <= 1'b1;
      @(posedge sys_clk_i);
      timer_match_i <= 1'b0;
    end
    rdc(SSWC_STAT_OFS, stat(1'b0, n));
    wr(SSWC_CTRL_OFS, 8'h00);
    wr(SSWC_STAT_OFS, 8'h0F);
    global_irq_enable_i <= 1'b1;
    wr(SSWC_CTRL_OFS, 8'h02);
    rdc(SSWC_CTRL_OFS, 8'h00);
    chk({7'h00, overflow_irq_o}, 8'h00);
    wr(SSWC_CTRL_OFS, 8'h40);
    rdc(SSWC_STAT_OFS, stat(1'b1, 4'h0));
    chk({7'h00, overflow_irq_o}, 8'h01);
    wr(SSWC_STAT_OFS, 8'h40);
    settle;
    chk({7'h00, overflow_irq_o}, 8'h00);
    wr(SSWC_DATA_OFS, 8'h80);
    wr(SSWC_PORT_OFS, 8'h10);
    wr(SSWC_CTRL_OFS, 8'h10);
    settle;
    chk({6'h00, data_out_oe_o, data_out_o}, 8'h03);
    wr(SSWC_CTRL_OFS, 8'h12);
    settle;
    chk({6'h00, data_out_oe_o, data_out_o}, 8'h02);
    rdc(SSWC_DATA_OFS, {7'h00, pd});
    wr(SSWC_CTRL_OFS, 8'h00);
    wr(SSWC_DATA_OFS, 8'h80);
    settle;
    chk({6'h00, data_out_oe_o, data_out_o}, 8'h02);
    wr(SSWC_PORT_OFS, 8'h00);
    wr(SSWC_CTRL_OFS, 8'h09);
    rdc(SSWC_PORT_OFS, 8'h04);
    wr(SSWC_STAT_OFS, 8'h00);
    wr(SSWC_CTRL_OFS, 8'h0A);
    wr(SSWC_CTRL_OFS, 8'h0B);
    rdc(SSWC_STAT_OFS, 8'h01);
    rdc(SSWC_PORT_OFS, 8'h00);
    for (int j = 0; j < 2; j++)
    begin
      c = (j == 0) ? 8'h08 : 8'h0C;
      wr(SSWC_CTRL_OFS, c);
      wr(SSWC_DATA_OFS, 8'h00);
      wr(SSWC_STAT_OFS, 8'h00);
      seed = lfsr(seed);
      k = seed[2:0] | 3'h1;
      peer.burst(k, seed[15:8]);
      settle;
      rdc(SSWC_STAT_OFS, stat(1'b0, {k, 1'b0}));
      rdc(SSWC_DATA_OFS, seed[15:8] & ~(8'hFF << k));
    end
    wr(SSWC_CTRL_OFS, 8'h00);
    wr(SSWC_DATA_OFS, 8'h80);
    wr(SSWC_PORT_OFS, 8'h62);
    wr(SSWC_CTRL_OFS, 8'h20);
    settle;
    chk({6'h00, sda_oe_o, scl_oe_o}, 8'h01);
    wr(SSWC_PORT_OFS, 8'h66);
    wr(SSWC_DATA_OFS, 8'h00);
    settle;
    chk({6'h00, sda_oe_o, scl_oe_o}, 8'h02);
    wr(SSWC_PORT_OFS, 8'h06);
    settle;
    chk({6'h00, di_pullup_o, ck_pullup_o}, 8'h00);
    wr(SSWC_PORT_OFS, 8'h46);
    wr(SSWC_CTRL_OFS, 8'h30);
    wr(SSWC_STAT_OFS, 8'h0F);
    wr(SSWC_CTRL_OFS, 8'h32);
    settle;
    chk({7'h00, scl_oe_o}, 8'h01);
    wr(SSWC_STAT_OFS, 8'h40);
    settle;
    chk({7'h00, scl_oe_o}, 8'h00);
    wr(SSWC_PORT_OFS, 8'h44);
    settle;
    peer.start_cond();
    settle;
    rdc(SSWC_STAT_OFS, 8'h80);
    chk({7'h00, scl_oe_o}, 8'h01);
    wr(SSWC_STAT_OFS, 8'h80);
    settle;
    chk({7'h00, scl_oe_o}, 8'h00);
    wrap_up;
  end
endmodule
`default_nettype wire
